// ===== rtl/odc_debug_ctrl.sv
// On-chip debugger control: register, halt, breakpoint, reset, serial link
// What this block does
// - One open-drain debug pin carries both transmit and receive data.
// - Link is half-duplex; never drive while the host transmits.
// - Bytes framed as standard asynchronous start, eight data, stop.
// - Halt flag set stops instruction fetch; clearing resumes the processor.
// - Decoded breakpoint opcode with breakpoints allowed sets the halt flag.
// - With read protect active, writing zero cannot clear the halt flag.
// - With breakpoints disallowed, the breakpoint opcode acts as no-operation.
// - With notify enabled, a breakpoint sends acknowledge character to host.
// - Writing one to reset bit resets the device but not the debugger.
// - Reset bit self-clears after the reset sequence; writing zero does nothing.
// - Control bits four to one read as zero.
`timescale 1ns/1ps
`default_nettype none
`include "odc_params.svh"
module odc_debug_ctrl
   import odc_pkg::*;
#(
   parameter logic [15:0] BAUD_DIV   = `ODC_BAUD_DIV,
   parameter logic [7:0]  RST_CYCLES = `ODC_RST_CYCLES,
   parameter int          FIFO_DEPTH = 16
) (
   // Clock and reset
   input  wire logic       clk_sys_i,
   input  wire logic       rst_n_i,
   // Register port
   input  wire logic [3:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   output logic [7:0]      reg_rdata_o,
   // Processor side
   input  wire logic       opcode_valid_i,
   input  wire logic [7:0] opcode_i,
   input  wire logic       cpu_halted_i,
   input  wire logic       read_protect_option_i,
   output logic            fetch_stall_o,
   output logic            breakpoint_nop_o,
   output logic            device_reset_o,
   input  wire logic       device_reset_done_i,
   // Debug pin
   input  wire logic       debug_line_pin_i,
   output logic            debug_line_pin_o,
   output logic            debug_line_pin_oe_o
);
   typedef struct packed {
      logic             halt;
      logic             brk_allow;
      logic             notify;
      logic             devrst;
      logic [7:0]       rst_cnt;
      logic             ack_pend;
      logic [2:0]       sync;
      logic             line;
      odc_tx_state_type tx_st;
      logic [15:0]      tx_div;
      logic [3:0]       tx_bit;
      logic [9:0]       tx_sh;
      logic             tx_drive;
      odc_rx_state_type rx_st;
      logic [15:0]      rx_div;
      logic [3:0]       rx_bit;
      logic [7:0]       rx_sh;
      logic [7:0]       rx_data;
      logic             rx_full;
      logic [7:0]       rdata;
   } odc_state_type;
   odc_state_type st_reg;
   odc_state_type st_next;
   logic          brk_hit;
   logic          ctrl_wr;
   logic          fifo_in_valid;
   logic          fifo_in_ready;
   logic [7:0]    fifo_in_data;
   logic          fifo_out_valid;
   logic          fifo_out_ready;
   logic [7:0]    fifo_out_data;
   logic [7:0]    ctrl_view;
   logic [7:0]    stat_view;
   logic          tx_wr;
   logic          ack_push;
   assign brk_hit = opcode_valid_i && (opcode_i == `ODC_BRK_OPCODE) && st_reg.brk_allow;
   assign ctrl_wr = reg_wr_i && (reg_addr_i == `ODC_ADDR_CTRL);
   assign tx_wr   = reg_wr_i && (reg_addr_i == `ODC_ADDR_TXDATA);
   // Software transmit bytes and ack share the FIFO
   // A software byte takes the cycle; the ack waits for a cycle without one, so the ack is never lost
   assign ack_push      = st_reg.ack_pend && cpu_halted_i && !tx_wr;
   assign fifo_in_valid = ack_push || tx_wr;
   assign fifo_in_data  = ack_push ? `ODC_ACK_CHAR : reg_wdata_i;
   // Drain only while line idle and no reception running
   assign fifo_out_ready = (st_reg.tx_st == ODC_TX_IDLE) && (st_reg.rx_st == ODC_RX_IDLE)
                           && st_reg.line;
   odc_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_sys_i   (clk_sys_i),
      .rst_n_i     (rst_n_i),
      .in_valid_i  (fifo_in_valid),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (fifo_in_data),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (fifo_out_ready),
      .out_data_o  (fifo_out_data)
   );
   always_comb
   begin
      ctrl_view = 8'h00;
      ctrl_view[`ODC_BIT_HALT]     = st_reg.halt;
      ctrl_view[`ODC_BIT_BRKALLOW] = st_reg.brk_allow;
      ctrl_view[`ODC_BIT_NOTIFY]   = st_reg.notify;
      ctrl_view[`ODC_BIT_DEVRST]   = st_reg.devrst;
      stat_view = {4'h0, st_reg.rx_st == ODC_RX_SHIFT, st_reg.tx_st == ODC_TX_SHIFT,
                   fifo_in_ready, st_reg.rx_full};
   end
   always_comb
   begin
      st_next = st_reg;
      // Pin input synchroniser; third and second must agree
      st_next.sync = {st_reg.sync[1:0], debug_line_pin_i};
      if (st_reg.sync[2] == st_reg.sync[1])
      begin
         st_next.line = st_reg.sync[2];
      end
      // Control register writes
      if (ctrl_wr)
      begin
         st_next.brk_allow = reg_wdata_i[`ODC_BIT_BRKALLOW];
         st_next.notify    = reg_wdata_i[`ODC_BIT_NOTIFY];
         if (reg_wdata_i[`ODC_BIT_HALT])
         begin
            st_next.halt = 1'b1;
         end
         else if (!read_protect_option_i)
         begin
            st_next.halt = 1'b0;
         end
         // A running reset ignores a further request; a zero does nothing
         if (reg_wdata_i[`ODC_BIT_DEVRST] && !st_reg.devrst)
         begin
            st_next.devrst  = 1'b1;
            st_next.rst_cnt = RST_CYCLES;
         end
      end
      // Queued ack leaves once it is in the FIFO
      if (ack_push && fifo_in_ready)
      begin
         st_next.ack_pend = 1'b0;
      end
      // Breakpoint sets halt; wins over a clearing write
      // A new breakpoint wins over the ack leaving in the same cycle
      if (brk_hit)
      begin
         st_next.halt = 1'b1;
         if (st_reg.notify || (ctrl_wr && reg_wdata_i[`ODC_BIT_NOTIFY]))
         begin
            st_next.ack_pend = 1'b1;
         end
      end
      // Device reset sequence, self-clearing
      if (st_reg.devrst)
      begin
         if (st_reg.rst_cnt != 8'h00)
         begin
            st_next.rst_cnt = st_reg.rst_cnt - 8'h01;
         end
         else if (device_reset_done_i)
         begin
            st_next.devrst = 1'b0;
         end
      end
      // Transmitter
      unique case (st_reg.tx_st)
         ODC_TX_IDLE:
         begin
            st_next.tx_drive = 1'b0;
            if (fifo_out_valid && fifo_out_ready)
            begin
               st_next.tx_st    = ODC_TX_SHIFT;
               st_next.tx_sh    = {1'b1, fifo_out_data, 1'b0};
               st_next.tx_bit   = `ODC_FRAME_BITS;
               st_next.tx_div   = BAUD_DIV;
               st_next.tx_drive = 1'b1;
            end
         end
         ODC_TX_SHIFT:
         begin
            if (st_reg.tx_div != 16'h0000)
            begin
               st_next.tx_div = st_reg.tx_div - 16'h0001;
            end
            else
            begin
               st_next.tx_div = BAUD_DIV;
               st_next.tx_sh  = {1'b1, st_reg.tx_sh[9:1]};
               st_next.tx_bit = st_reg.tx_bit - 4'h1;
               // Stop bit releases the pin before returning idle
               if (st_reg.tx_bit == 4'h1)
               begin
                  st_next.tx_st    = ODC_TX_IDLE;
                  st_next.tx_drive = 1'b0;
               end
            end
         end
         default:
         begin
            st_next.tx_st    = ODC_TX_IDLE;
            st_next.tx_drive = 1'b0;
         end
      endcase
      // Receiver, off while transmitting
      unique case (st_reg.rx_st)
         ODC_RX_IDLE:
         begin
            if (st_reg.tx_st == ODC_TX_IDLE && !st_reg.line)
            begin
               st_next.rx_st  = ODC_RX_SHIFT;
               // Half a bit time to land in mid-bit
               st_next.rx_div = {1'b0, BAUD_DIV[15:1]};
               st_next.rx_bit = `ODC_FRAME_BITS;
            end
         end
         ODC_RX_SHIFT:
         begin
            if (st_reg.rx_div != 16'h0000)
            begin
               st_next.rx_div = st_reg.rx_div - 16'h0001;
            end
            else
            begin
               st_next.rx_div = BAUD_DIV;
               st_next.rx_bit = st_reg.rx_bit - 4'h1;
               // Start bit gone by mid-bit: false start
               if (st_reg.rx_bit == `ODC_FRAME_BITS && st_reg.line)
               begin
                  st_next.rx_st = ODC_RX_IDLE;
               end
               else if (st_reg.rx_bit == 4'h1)
               begin
                  st_next.rx_st = ODC_RX_IDLE;
                  if (st_reg.line)
                  begin
                     st_next.rx_data = st_reg.rx_sh;
                     st_next.rx_full = 1'b1;
                  end
               end
               else if (st_reg.rx_bit != `ODC_FRAME_BITS)
               begin
                  st_next.rx_sh = {st_reg.line, st_reg.rx_sh[7:1]};
               end
            end
         end
         default:
         begin
            st_next.rx_st = ODC_RX_IDLE;
         end
      endcase
      // Register reads; reading receive data clears the full flag
      st_next.rdata = 8'h00;
      if (reg_rd_i)
      begin
         unique case (reg_addr_i)
            `ODC_ADDR_CTRL:   st_next.rdata = ctrl_view;
            `ODC_ADDR_STATUS: st_next.rdata = stat_view;
            `ODC_ADDR_RXDATA:
            begin
               st_next.rdata   = st_reg.rx_data;
               st_next.rx_full = 1'b0;
            end
            default:          st_next.rdata = 8'h00;
         endcase
      end
      // A new byte wins over a clearing read
      if (st_reg.rx_st == ODC_RX_SHIFT && st_reg.rx_bit == 4'h1 && st_reg.rx_div == 16'h0000
          && st_reg.line)
      begin
         st_next.rx_full = 1'b1;
      end
   end
   // Pin path and line reset high, so no false start follows reset
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         st_reg       <= '0;
         st_reg.sync  <= 3'b111;
         st_reg.line  <= 1'b1;
         st_reg.tx_sh <= 10'h3FF;
      end
      else
      begin
         st_reg <= st_next;
      end
   end
   assign reg_rdata_o         = st_reg.rdata;
   assign fetch_stall_o       = st_reg.halt;
   assign breakpoint_nop_o    = opcode_valid_i && (opcode_i == `ODC_BRK_OPCODE)
                                && !st_reg.brk_allow;
   assign device_reset_o      = st_reg.devrst;
   // Open drain: only ever pull low
   assign debug_line_pin_o    = 1'b0;
   assign debug_line_pin_oe_o = st_reg.tx_drive && !st_reg.tx_sh[0];
endmodule // odc_debug_ctrl
`default_nettype wire

// ===== rtl/odc_params.svh
// Constants for the on-chip debugger control block
`ifndef ODC_PARAMS_SVH
`define ODC_PARAMS_SVH
`define ODC_ADDR_CTRL      4'h0
`define ODC_ADDR_STATUS    4'h1
`define ODC_ADDR_TXDATA    4'h2
`define ODC_ADDR_RXDATA    4'h3
`define ODC_CTRL_RESET     8'h00
`define ODC_BIT_HALT       7
`define ODC_BIT_BRKALLOW   6
`define ODC_BIT_NOTIFY     5
`define ODC_BIT_DEVRST     0
`define ODC_BRK_OPCODE     8'h00
`define ODC_ACK_CHAR       8'hFF
`define ODC_BAUD_DIV       16'h0364
`define ODC_FRAME_BITS     4'hA
`define ODC_RST_CYCLES     8'h40
`endif

// ===== rtl/odc_pkg.sv
// Types for the on-chip debugger control block
package odc_pkg;
   typedef enum logic [1:0] {ODC_TX_IDLE, ODC_TX_SHIFT} odc_tx_state_type;
   typedef enum logic [1:0] {ODC_RX_IDLE, ODC_RX_SHIFT} odc_rx_state_type;
endpackage

// ===== rtl/odc_fifo.sv
// Valid/ready FIFO with parameterised width and depth
`timescale 1ns/1ps
`default_nettype none
module odc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic             clk_sys_i,
   input  wire logic             rst_n_i,
   // Fill side
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic [WIDTH-1:0]      out_data_o
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0]   cnt;
   } odc_fifo_state_type;
   odc_fifo_state_type st_reg;
   odc_fifo_state_type st_next;
   logic [WIDTH-1:0]   mem [DEPTH];
   logic               push;
   logic               pop;
   assign in_ready_o  = (st_reg.cnt != DEPTH[AW:0]);
   assign out_valid_o = (st_reg.cnt != '0);
   assign out_data_o  = mem[st_reg.rd];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;
   always_comb
   begin
      st_next = st_reg;
      if (push)
      begin
         st_next.wr = st_reg.wr + 1'b1;
      end
      if (pop)
      begin
         st_next.rd = st_reg.rd + 1'b1;
      end
      st_next.cnt = st_reg.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end
   always_ff @(posedge clk_sys_i)
   begin
      if (push)
      begin
         mem[st_reg.wr] <= in_data_i;
      end
   end
endmodule // odc_fifo
`default_nettype wire

// ===== tb/odc_debug_ctrl_sva.sv
// Assertions for the debugger control block
`timescale 1ns/1ps
`default_nettype none
module odc_debug_ctrl_sva #(
   parameter logic [7:0] RST_CYCLES = 8'h40
) (
   input wire logic       clk_sys_i, rst_n_i, reg_wr_i, reg_rd_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i, reg_rdata_o, opcode_i,
   input wire logic       opcode_valid_i, cpu_halted_i, read_protect_option_i,
   input wire logic       fetch_stall_o, breakpoint_nop_o, device_reset_o,
   input wire logic       device_reset_done_i, debug_line_pin_i,
   input wire logic       debug_line_pin_o, debug_line_pin_oe_o
);
   logic       brk_reg;
   logic [8:0] rcnt_reg;
   wire logic  ctl_wr = reg_wr_i && reg_addr_i == 4'h0;
   wire logic  brk_hit = opcode_valid_i && opcode_i == 8'h00;
   // Shadow of the breakpoint allow bit
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
      if (!rst_n_i) brk_reg <= 1'b0;
      else if (ctl_wr) brk_reg <= reg_wdata_i[6];
   // Cycles the device reset request has stood
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
      if (!rst_n_i) rcnt_reg <= 9'h000;
      else if (!device_reset_o) rcnt_reg <= 9'h000;
      else if (rcnt_reg != 9'h1FF) rcnt_reg <= rcnt_reg + 9'h001;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   a_open_drain: assert property (!debug_line_pin_o)
      else $error("debug pin data not low");
   a_half_duplex: assert property (
      (!debug_line_pin_oe_o && !debug_line_pin_i)[*4] |=> !debug_line_pin_oe_o)
      else $error("drove line while host low");
   a_halt_clear: assert property (
      ctl_wr && !reg_wdata_i[7] && !read_protect_option_i && !(brk_hit && brk_reg)
      |=> !fetch_stall_o) else $error("halt not cleared");
   a_brk_halts: assert property (brk_hit && brk_reg |=> fetch_stall_o)
      else $error("breakpoint did not halt");
   a_protect_hold: assert property (
      fetch_stall_o && read_protect_option_i |=> fetch_stall_o)
      else $error("halt cleared under read protect");
   a_brk_nop: assert property (brk_hit && !brk_reg |-> breakpoint_nop_o)
      else $error("breakpoint not run as nop");
   a_reset_start: assert property (ctl_wr && reg_wdata_i[0] |=> device_reset_o)
      else $error("device reset not requested");
   a_reset_wait: assert property (
      device_reset_o && !device_reset_done_i |=> device_reset_o)
      else $error("device reset dropped early");
   a_reset_min: assert property ($fell(device_reset_o) |-> rcnt_reg > RST_CYCLES)
      else $error("device reset too short");
   a_zero_bits: assert property (
      reg_rd_i && reg_addr_i == 4'h0 |=> reg_rdata_o[4:1] == 4'h0)
      else $error("control bits four to one not zero");
   c_halt: cover property ($rose(fetch_stall_o));
   c_reset: cover property ($fell(device_reset_o));
   c_send: cover property ($rose(debug_line_pin_oe_o));
endmodule // odc_debug_ctrl_sva
bind odc_debug_ctrl odc_debug_ctrl_sva #(.RST_CYCLES(RST_CYCLES)) odc_debug_ctrl_sva_inst (
   .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
   .opcode_i(opcode_i), .opcode_valid_i(opcode_valid_i), .cpu_halted_i(cpu_halted_i),
   .read_protect_option_i(read_protect_option_i), .fetch_stall_o(fetch_stall_o),
   .breakpoint_nop_o(breakpoint_nop_o), .device_reset_o(device_reset_o),
   .device_reset_done_i(device_reset_done_i), .debug_line_pin_i(debug_line_pin_i),
   .debug_line_pin_o(debug_line_pin_o), .debug_line_pin_oe_o(debug_line_pin_oe_o));
`default_nettype wire

// ===== tb/odc_host_model.sv
// Debug host model on the serial line
`timescale 1ns/1ps
`default_nettype none
module odc_host_model #(
   parameter int BIT = 5
) (
   input  wire logic  clk_sys_i,
   input  wire logic  line_i,
   output logic       line_oe_o,
   output logic [7:0] rx_byte_o,
   output int         rx_count_o
);
   logic sending = 1'b0;
   initial
   begin
      line_oe_o = 1'b0;
      rx_byte_o = 8'h00;
      rx_count_o = 0;
   end
   // Start bit, eight data bits LSB first, stop bit
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      sending = 1'b1;
      wait (line_i);
      for (int i = 0; i < 10; i++)
      begin
         @(posedge clk_sys_i);
         line_oe_o <= !f[i];
         repeat (BIT - 1) @(posedge clk_sys_i);
      end
      sending = 1'b0;
   endtask
   // Receiver sampling mid-bit
   always
   begin
      @(negedge line_i);
      if (!sending)
      begin
         repeat (BIT + BIT / 2) @(posedge clk_sys_i);
         for (int i = 0; i < 8; i++)
         begin
            rx_byte_o[i] = line_i;
            repeat (BIT) @(posedge clk_sys_i);
         end
         if (line_i) rx_count_o++;
      end
   end
endmodule // odc_host_model
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the debugger control block
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic       clk_sys_i = 1'b0;
   logic       rst_n_i = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00, rdata, opc = 8'h01, d;
   logic       wr = 1'b0, rd = 1'b0, opv = 1'b0, halted = 1'b0, rp = 1'b0, done = 1'b0;
   logic       stall, nop, drst, pin_o, oe, host_oe;
   logic [7:0] hbyte;
   int         hcnt, errors = 0, cmp_count = 0;
   wire logic  line = !(oe || host_oe);
   always #5 clk_sys_i = !clk_sys_i;
   odc_debug_ctrl #(.BAUD_DIV(16'h0004), .RST_CYCLES(8'h02)) odc_debug_ctrl_inst (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .opcode_valid_i(opv),
      .opcode_i(opc), .cpu_halted_i(halted), .read_protect_option_i(rp),
      .fetch_stall_o(stall), .breakpoint_nop_o(nop), .device_reset_o(drst),
      .device_reset_done_i(done), .debug_line_pin_i(line), .debug_line_pin_o(pin_o),
      .debug_line_pin_oe_o(oe));
   odc_host_model #(.BIT(5)) odc_host_model_inst (.clk_sys_i(clk_sys_i), .line_i(line),
      .line_oe_o(host_oe), .rx_byte_o(hbyte), .rx_count_o(hcnt));
   task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
      cmp_count++;
      if (s !== e)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk_sys_i);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk_sys_i);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
      @(posedge clk_sys_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys_i);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic breakpoint_opcode(output logic n);
      @(posedge clk_sys_i);
      opv <= 1'b1;
      opc <= 8'h00;
      #1 n = nop;
      @(posedge clk_sys_i);
      opv <= 1'b0;
      opc <= 8'h01;
   endtask
   task automatic tally_and_finish();
      if (errors == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge clk_sys_i);
      errors++;
      tally_and_finish();
   end
   initial
   begin
      repeat (2) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      rd_reg(4'h0, d);
      check("ctrl reset", d, 8'h00);
      wr_reg(4'h0, 8'h1E);
      rd_reg(4'h0, d);
      check("ctrl reserved", d, 8'h00);
      breakpoint_opcode(d[0]);
      check("nop", d[0], 8'h01);
      #1 check("no halt", stall, 8'h00);
      wr_reg(4'h0, 8'h60);
      breakpoint_opcode(d[0]);
      #1 check("halt", stall, 8'h01);
      repeat (30) @(posedge clk_sys_i);
      check("ack early", 8'(hcnt), 8'h00);
      halted <= 1'b1;
      repeat (2000) if (hcnt < 1) @(posedge clk_sys_i);
      check("ack", hbyte, 8'hFF);
      check("ack count", 8'(hcnt), 8'h01);
      rp <= 1'b1;
      wr_reg(4'h0, 8'h40);
      #1 check("protect", stall, 8'h01);
      breakpoint_opcode(d[0]);
      check("no nop", d[0], 8'h00);
      @(posedge clk_sys_i) rp <= 1'b0;
      wr_reg(4'h0, 8'h00);
      #1 check("resume", stall, 8'h00);
      @(posedge clk_sys_i) halted <= 1'b0;
      wr_reg(4'h0, 8'h81);
      #1 check("dev reset", drst, 8'h01);
      wr_reg(4'h0, 8'h80);
      #1 check("zero no effect", drst, 8'h01);
      repeat (5) @(posedge clk_sys_i);
      check("wait done", drst, 8'h01);
      done <= 1'b1;
      repeat (20) if (drst) @(posedge clk_sys_i);
      done <= 1'b0;
      rd_reg(4'h0, d);
      check("reset clear", d, 8'h80);
      wr_reg(4'h0, 8'h00);
      #1 check("write zero", drst, 8'h00);
      wr_reg(4'h2, 8'hA5);
      repeat (2000) if (hcnt < 2) @(posedge clk_sys_i);
      check("tx byte", hbyte, 8'hA5);
      odc_host_model_inst.send_byte(8'h3C);
      repeat (20) @(posedge clk_sys_i);
      rd_reg(4'h1, d);
      check("rx full", d & 8'h01, 8'h01);
      rd_reg(4'h3, d);
      check("rx data", d, 8'h3C);
      rd_reg(4'h1, d);
      check("rx taken", d & 8'h01, 8'h00);
      rd_reg(4'hF, d);
      check("unmapped", d, 8'h00);
      for (int i = 0; i < 18; i++) wr_reg(4'h2, 8'(i));
      rd_reg(4'h1, d);
      check("fifo refuses", d & 8'h02, 8'h00);
      repeat (1500) if (hcnt < 19) @(posedge clk_sys_i);
      check("fifo count", 8'(hcnt), 8'h13);
      check("fifo last", hbyte, 8'h10);
      repeat (60) @(posedge clk_sys_i);
      rd_reg(4'h1, d);
      check("fifo drained", d & 8'h06, 8'h02);
      tally_and_finish();
   end
endmodule // tb
`default_nettype wire
